// *** common/scm_pkg.sv ***
// Constants and types shared by the serializer clock mode control block.
package scm_pkg;

    // Register offsets on the register access port.
    localparam logic [7:0] SCM_OFS_MODE = 8'h03;
    localparam logic [7:0] SCM_OFS_BC_FMT = 8'h04;
    localparam logic [7:0] SCM_OFS_CLK_CFG = 8'h05;
    localparam logic [7:0] SCM_OFS_CLKOUT_M = 8'h06;
    localparam logic [7:0] SCM_OFS_CLKOUT_N = 8'h07;
    localparam logic [7:0] SCM_OFS_PAR_CFG = 8'h10;
    localparam logic [7:0] SCM_OFS_PAR_DT = 8'h11;

    // Field positions.
    localparam int SCM_MODE_LSB = 0;
    localparam int SCM_MODE_OVR_BIT = 4;
    localparam int SCM_EXT_DIV_LSB = 0;
    localparam int SCM_OSC_SEL_BIT = 3;
    localparam int SCM_PRESC_LSB = 0;
    localparam int SCM_M_LSB = 3;
    localparam int SCM_FMT_BIT = 0;

    // Reset values.
    localparam logic [7:0] SCM_RST_MODE = 8'h00;
    localparam logic [7:0] SCM_RST_BC_FMT = 8'h00;
    localparam logic [7:0] SCM_RST_CLK_CFG = 8'h08;
    localparam logic [7:0] SCM_RST_CLKOUT_M = 8'h08;
    localparam logic [7:0] SCM_RST_CLKOUT_N = 8'h01;
    localparam logic [7:0] SCM_RST_PAR_CFG = 8'h00;
    localparam logic [7:0] SCM_RST_PAR_DT = 8'h00;

    // Operating mode codes held in the mode field.
    typedef enum logic [2:0] {
        SCM_MODE_SYNC = 3'b000,
        SCM_MODE_EXT = 3'b010,
        SCM_MODE_INT = 3'b011,
        SCM_MODE_PAR = 3'b101
    } scm_mode_t;

    // Output clock prescaler codes; code 2'b11 is refused.
    typedef enum logic [1:0] {
        SCM_PRESC_DIV4 = 2'b00,
        SCM_PRESC_DIV8 = 2'b01,
        SCM_PRESC_DIV16 = 2'b10
    } scm_presc_t;

    localparam logic [4:0] SCM_PRESC_VAL4 = 5'h04;
    localparam logic [4:0] SCM_PRESC_VAL8 = 5'h08;
    localparam logic [4:0] SCM_PRESC_VAL16 = 5'h10;

    // Selected reference source.
    typedef enum logic [1:0] {
        SCM_REF_BACKCH = 2'b00,
        SCM_REF_EXT_PIN = 2'b01,
        SCM_REF_OSC_FULL = 2'b10,
        SCM_REF_OSC_HALF = 2'b11
    } scm_ref_t;

    // External clock input divider codes.
    localparam logic [2:0] SCM_EXT_DIV_X80 = 3'b000;
    localparam logic [2:0] SCM_EXT_DIV_X40 = 3'b001;

    // Forward-channel rate and CSI-2 bandwidth multipliers of the reference.
    localparam logic [7:0] SCM_MULT_SYNC = 8'hA0;
    localparam logic [7:0] SCM_BW_SYNC = 8'h80;
    localparam logic [7:0] SCM_MULT_X80 = 8'h50;
    localparam logic [7:0] SCM_BW_X80 = 8'h40;
    localparam logic [7:0] SCM_MULT_X40 = 8'h28;
    localparam logic [7:0] SCM_BW_X40 = 8'h20;
    localparam logic [7:0] SCM_MULT_PAR = 8'h1C;
    localparam logic [7:0] SCM_BW_PAR_TEN = 8'h14;
    localparam logic [7:0] SCM_BW_PAR_TWELVE_HF = 8'h12;

endpackage

// *** common/scm_gen_if.sv ***
// Interface between the mode controller and the sensor clock generator.
`timescale 1ns/1ps
interface scm_gen_if;
    logic ref_tick;
    logic enable;
    logic [7:0] rate_mult;
    logic [4:0] m;
    logic [7:0] n;
    logic [4:0] presc;
    logic clk_out;

    modport ctrl (
        output ref_tick,
        output enable,
        output rate_mult,
        output m,
        output n,
        output presc,
        input clk_out
    );

    modport gen (
        input ref_tick,
        input enable,
        input rate_mult,
        input m,
        input n,
        input presc,
        output clk_out
    );
endinterface

// *** hdl/scm_clkout_gen.sv ***
// Fractional M/N phase accumulator that produces the sensor reference clock.
`timescale 1ns/1ps
module scm_clkout_gen
    import scm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Controller side
    scm_gen_if.gen g
);

    logic [12:0] acc;
    logic [12:0] next_acc;
    logic out_q;
    logic next_out;

    logic [12:0] inc;
    logic [12:0] modulus;
    logic [13:0] sum;
    logic [13:0] rem;

    // Each reference edge adds rate*M units; one output period is presc*N units.
    assign inc = 13'(g.rate_mult) * 13'(g.m);
    assign modulus = 13'(g.presc) * 13'(g.n);
    assign sum = {1'b0, acc} + {1'b0, inc};
    assign rem = sum - {1'b0, modulus};

    always_comb begin
        next_acc = acc;
        next_out = out_q;
        if (!g.enable || modulus == 13'h0000) begin
            next_acc = 13'h0000;
            next_out = 1'b0;
        end else if (g.ref_tick) begin
            // Output is resampled per reference edge, so ratios above one half alias.
            if (sum >= {1'b0, modulus}) begin
                next_acc = (rem >= {1'b0, modulus}) ? 13'h0000 : rem[12:0];
            end else begin
                next_acc = sum[12:0];
            end
            next_out = (next_acc < (modulus >> 1));
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc <= 13'h0000;
            out_q <= 1'b0;
        end else begin
            acc <= next_acc;
            out_q <= next_out;
        end
    end

    assign g.clk_out = out_q;

endmodule

// *** hdl/scm_top.sv ***
// Clocking mode selection and sensor reference clock control of the serializer.
//
// Notes on behaviour
// - Sync mode: back-channel reference, x160, bandwidth x128.
// - External mode: pin reference, x80 or x40 by divider.
// - Internal mode: oscillator reference, rate bit picks full/half.
// - Sensor clock off in internal oscillator mode.
// - Sensor clock is rate times M over prescaler*N.
// - Prescaler accepts only 16, 8, 4; resets to 4.
// - Parallel mode: x28, bandwidth x20 or x18.
// - Mode field reports mode; read-only while override clear.
// - Mode captured from strap on power-down release.
// - Override bit makes mode field writable by software.
// - Mode codes: sync 0, external 2, internal 3, parallel 5.
`timescale 1ns/1ps
module scm_top
    import scm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Device pins
    input wire logic power_down_pin_n,
    input wire logic [2:0] mode_strap,
    input wire logic backchannel_clk,
    input wire logic ref_clock_input_pin,
    input wire logic osc_full_rate,
    input wire logic osc_half_rate,
    // Register access port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Clocking status
    output logic [2:0] mode_active,
    output logic [1:0] ref_source,
    output logic [7:0] forward_rate_mult,
    output logic [7:0] csi_bw_limit_mult,
    // Sensor reference clock
    output logic sensor_ref_clk,
    output logic sensor_ref_clk_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts once stages two and
    // three agree.

    localparam int NPIN = 8;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_filt;
    logic [NPIN-1:0] pin_prev;

    assign pin_raw = {mode_strap, power_down_pin_n, osc_half_rate, osc_full_rate,
                      ref_clock_input_pin, backchannel_clk};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            logic s1, s2, s3, filt, prev;
            logic next_filt;
            always_comb begin
                next_filt = (s2 == s3) ? s3 : filt;
            end
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    filt <= 1'b0;
                    prev <= 1'b0;
                end else begin
                    s1 <= pin_raw[gi];
                    s2 <= s1;
                    s3 <= s2;
                    filt <= next_filt;
                    prev <= filt;
                end
            end
            assign pin_filt[gi] = filt;
            assign pin_prev[gi] = prev;
        end
    endgenerate

    logic [3:0] ref_rise;
    logic pd_release;
    logic [2:0] strap_mode;

    assign ref_rise = pin_filt[3:0] & ~pin_prev[3:0];
    assign pd_release = pin_filt[4] & ~pin_prev[4];
    assign strap_mode = pin_filt[7:5];

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0] mode_ctrl, bc_fmt, clk_cfg, clkout_m, clkout_n, par_cfg, par_dt;
    logic [7:0] next_mode_ctrl, next_bc_fmt, next_clk_cfg, next_clkout_m;
    logic [7:0] next_clkout_n, next_par_cfg, next_par_dt, next_rdata;
    logic [7:0] rdata_q;

    always_comb begin
        next_mode_ctrl = mode_ctrl;
        next_bc_fmt = bc_fmt;
        next_clk_cfg = clk_cfg;
        next_clkout_m = clkout_m;
        next_clkout_n = clkout_n;
        next_par_cfg = par_cfg;
        next_par_dt = par_dt;
        next_rdata = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                SCM_OFS_MODE: begin
                    next_mode_ctrl[SCM_MODE_OVR_BIT] = reg_wdata[SCM_MODE_OVR_BIT];
                    // The mode field is taken only when the override bit is 1.
                    if (reg_wdata[SCM_MODE_OVR_BIT]) begin
                        next_mode_ctrl[SCM_MODE_LSB +: 3] = reg_wdata[SCM_MODE_LSB +: 3];
                    end
                end
                SCM_OFS_BC_FMT: next_bc_fmt = reg_wdata;
                SCM_OFS_CLK_CFG: next_clk_cfg = reg_wdata;
                SCM_OFS_CLKOUT_M: begin
                    next_clkout_m[7:2] = reg_wdata[7:2];
                    // A write with the unused prescaler code keeps the old value.
                    if (reg_wdata[SCM_PRESC_LSB +: 2] != 2'b11) begin
                        next_clkout_m[SCM_PRESC_LSB +: 2] = reg_wdata[SCM_PRESC_LSB +: 2];
                    end
                end
                SCM_OFS_CLKOUT_N: next_clkout_n = reg_wdata;
                SCM_OFS_PAR_CFG: next_par_cfg = reg_wdata;
                SCM_OFS_PAR_DT: next_par_dt = reg_wdata;
                default: begin
                end
            endcase
        end
        // The power-down release recaptures the strap and wins over a write.
        if (pd_release) begin
            next_mode_ctrl[SCM_MODE_LSB +: 3] = strap_mode;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                SCM_OFS_MODE: next_rdata = {3'h0, mode_ctrl[4], 1'b0, mode_ctrl[2:0]};
                SCM_OFS_BC_FMT: next_rdata = bc_fmt;
                SCM_OFS_CLK_CFG: next_rdata = clk_cfg;
                SCM_OFS_CLKOUT_M: next_rdata = clkout_m;
                SCM_OFS_CLKOUT_N: next_rdata = clkout_n;
                SCM_OFS_PAR_CFG: next_rdata = par_cfg;
                SCM_OFS_PAR_DT: next_rdata = par_dt;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_ctrl <= SCM_RST_MODE;
            bc_fmt <= SCM_RST_BC_FMT;
            clk_cfg <= SCM_RST_CLK_CFG;
            clkout_m <= SCM_RST_CLKOUT_M;
            clkout_n <= SCM_RST_CLKOUT_N;
            par_cfg <= SCM_RST_PAR_CFG;
            par_dt <= SCM_RST_PAR_DT;
            rdata_q <= 8'h00;
        end else begin
            mode_ctrl <= next_mode_ctrl;
            bc_fmt <= next_bc_fmt;
            clk_cfg <= next_clk_cfg;
            clkout_m <= next_clkout_m;
            clkout_n <= next_clkout_n;
            par_cfg <= next_par_cfg;
            par_dt <= next_par_dt;
            rdata_q <= next_rdata;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode: reference source, rate and bandwidth multipliers.

    logic [1:0] sel_ref, next_ref;
    logic [7:0] rate_q, bw_q, next_rate, next_bw;
    logic active_q, next_active;
    logic [2:0] mode_q;
    logic [2:0] ext_div;

    assign ext_div = clk_cfg[SCM_EXT_DIV_LSB +: 3];

    always_comb begin
        next_ref = SCM_REF_BACKCH;
        next_rate = 8'h00;
        next_bw = 8'h00;
        next_active = 1'b0;
        unique case (mode_ctrl[SCM_MODE_LSB +: 3])
            SCM_MODE_SYNC: begin
                next_ref = SCM_REF_BACKCH;
                next_rate = SCM_MULT_SYNC;
                next_bw = SCM_BW_SYNC;
                next_active = 1'b1;
            end
            SCM_MODE_EXT: begin
                next_ref = SCM_REF_EXT_PIN;
                // Divider codes other than b001 run as b000.
                next_rate = (ext_div == SCM_EXT_DIV_X40) ? SCM_MULT_X40 : SCM_MULT_X80;
                next_bw = (ext_div == SCM_EXT_DIV_X40) ? SCM_BW_X40 : SCM_BW_X80;
                next_active = 1'b1;
            end
            SCM_MODE_INT: begin
                next_ref = clk_cfg[SCM_OSC_SEL_BIT] ? SCM_REF_OSC_FULL : SCM_REF_OSC_HALF;
                next_rate = SCM_MULT_X80;
                next_bw = SCM_BW_X80;
                next_active = 1'b0;
            end
            SCM_MODE_PAR: begin
                next_ref = SCM_REF_EXT_PIN;
                next_rate = SCM_MULT_PAR;
                next_bw = bc_fmt[SCM_FMT_BIT] ? SCM_BW_PAR_TWELVE_HF : SCM_BW_PAR_TEN;
                next_active = 1'b1;
            end
            default: begin
                // Unused codes select the back-channel, zero both multipliers and stop the sensor clock.
                next_active = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_ref <= SCM_REF_BACKCH;
            rate_q <= 8'h00;
            bw_q <= 8'h00;
            active_q <= 1'b0;
            mode_q <= 3'h0;
        end else begin
            sel_ref <= next_ref;
            rate_q <= next_rate;
            bw_q <= next_bw;
            active_q <= next_active;
            mode_q <= mode_ctrl[SCM_MODE_LSB +: 3];
        end
    end

    assign mode_active = mode_q;
    assign ref_source = sel_ref;
    assign forward_rate_mult = rate_q;
    assign csi_bw_limit_mult = bw_q;
    assign sensor_ref_clk_active = active_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sensor reference clock generator.

    logic [4:0] presc_val;

    always_comb begin
        unique case (clkout_m[SCM_PRESC_LSB +: 2])
            SCM_PRESC_DIV8: presc_val = SCM_PRESC_VAL8;
            SCM_PRESC_DIV16: presc_val = SCM_PRESC_VAL16;
            default: presc_val = SCM_PRESC_VAL4;
        endcase
    end

    scm_gen_if gen_if ();

    assign gen_if.ref_tick = ref_rise[sel_ref];
    assign gen_if.enable = active_q;
    assign gen_if.rate_mult = rate_q;
    assign gen_if.m = clkout_m[SCM_M_LSB +: 5];
    assign gen_if.n = clkout_n;
    assign gen_if.presc = presc_val;

    scm_clkout_gen u_clkout (
        .clk (clk),
        .rstn (rstn),
        .g (gen_if.gen)
    );

    assign sensor_ref_clk = gen_if.clk_out;

endmodule

// *** verif/scm_far_model.sv ***
// Model of the paired deserializer and the sensor module reference sources.
`timescale 1ns/1ps
module scm_far_model #(
    parameter int BC_HALF = 40,
    parameter int EXT_HALF = 48,
    parameter int OSC_HALF = 40
) (
    // Reference clocks seen by the serializer
    output logic backchannel_clk,
    output logic ref_clock_input_pin,
    output logic osc_full_rate,
    output logic osc_half_rate
);
    initial begin
        {backchannel_clk, ref_clock_input_pin, osc_full_rate, osc_half_rate} = 4'h0;
    end
    // The recovered reference runs without gaps, so no local oscillator is needed.
    always #(BC_HALF) backchannel_clk = ~backchannel_clk;
    // The sensor data is timed from this same pin clock in parallel mode.
    always #(EXT_HALF) ref_clock_input_pin = ~ref_clock_input_pin;
    always #(OSC_HALF) osc_full_rate = ~osc_full_rate;
    always #(2 * OSC_HALF) osc_half_rate = ~osc_half_rate;
endmodule

// *** verif/scm_top_checker.sv ***
// Concurrent checks on the ports of the serializer clock mode controller.
`timescale 1ns/1ps
module scm_top_checker
    import scm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins and register port
    input wire logic power_down_pin_n,
    input wire logic [2:0] mode_strap,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Status
    input wire logic [2:0] mode_active,
    input wire logic [1:0] ref_source,
    input wire logic [7:0] forward_rate_mult,
    input wire logic [7:0] csi_bw_limit_mult,
    input wire logic sensor_ref_clk,
    input wire logic sensor_ref_clk_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [2:0] strap_q;
    logic [2:0] next_strap_q;
    // Outputs still hold their reset values at the first edge after release.
    logic live_q;
    logic [2:0] wr_mode;
    logic [7:0] fwd;
    logic [7:0] bw;
    assign wr_mode = reg_wdata[2:0];
    assign fwd = forward_rate_mult;
    assign bw = csi_bw_limit_mult;
    // The strap is only meaningful while the device is held in power-down.
    always_comb begin
        next_strap_q = power_down_pin_n ? strap_q : mode_strap;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_q <= 3'h0;
            live_q <= 1'b0;
        end else begin
            strap_q <= next_strap_q;
            live_q <= 1'b1;
        end
    end
    sequence mode_rd_s;
        !reg_wr ##1 (!reg_wr && reg_rd && reg_addr == SCM_OFS_MODE);
    endsequence
    sequence ovr_wr_s;
        (reg_wr && reg_addr == SCM_OFS_MODE && reg_wdata[4]) ##1 !reg_wr;
    endsequence
    sequence ro_wr_s;
        (reg_wr && reg_addr == SCM_OFS_MODE && !reg_wdata[4]) ##1 !reg_wr;
    endsequence
    sync_rates_a: assert property (live_q && mode_active == SCM_MODE_SYNC |->
        ref_source == 2'h0 && fwd == SCM_MULT_SYNC && bw == SCM_BW_SYNC && sensor_ref_clk_active)
        else $error("sync mode rates wrong");
    bw_under_rate_a: assert property (fwd != 8'h00 |-> bw < fwd)
        else $error("bandwidth limit not under line rate");
    ext_rates_a: assert property (mode_active == SCM_MODE_EXT |-> ref_source == 2'h1 &&
        (fwd == SCM_MULT_X80 && bw == SCM_BW_X80 || fwd == SCM_MULT_X40 && bw == SCM_BW_X40))
        else $error("external mode rates wrong");
    int_rates_a: assert property (mode_active == SCM_MODE_INT |-> ref_source[1] &&
        fwd == SCM_MULT_X80 && bw == SCM_BW_X80) else $error("internal mode rates wrong");
    int_clkoff_a: assert property (mode_active == SCM_MODE_INT |-> !sensor_ref_clk_active)
        else $error("sensor clock offered in internal mode");
    clk_idle_a: assert property (!sensor_ref_clk_active [*3] |-> !sensor_ref_clk)
        else $error("sensor clock toggles while inactive");
    par_rates_a: assert property (mode_active == SCM_MODE_PAR |-> ref_source == 2'h1 &&
        fwd == SCM_MULT_PAR && (bw == SCM_BW_PAR_TEN || bw == SCM_BW_PAR_TWELVE_HF))
        else $error("parallel mode rates wrong");
    bad_mode_a: assert property (!(mode_active inside {3'h0, 3'h2, 3'h3, 3'h5}) |->
        fwd == 8'h00 && bw == 8'h00 && !sensor_ref_clk_active) else $error("illegal mode active");
    mode_rd_a: assert property (mode_rd_s |=> reg_rdata[2:0] == $past(mode_active) &&
        !reg_rdata[3] && reg_rdata[7:5] == 3'h0) else $error("mode readback differs");
    mode_ro_a: assert property (ro_wr_s |=> $stable(mode_active))
        else $error("mode changed without override");
    mode_ovr_a: assert property (ovr_wr_s |=> mode_active == $past(wr_mode, 2))
        else $error("override write not applied");
    strap_cap_a: assert property ($rose(power_down_pin_n) |-> ##[3:8] mode_active == strap_q)
        else $error("strap not captured");
    presc_rd_a: assert property (reg_rd && reg_addr == SCM_OFS_CLKOUT_M |=>
        reg_rdata[1:0] != 2'b11) else $error("prescaler code refused value held");
endmodule

bind scm_top scm_top_checker chk_u (.clk(clk), .rstn(rstn), .power_down_pin_n(power_down_pin_n),
    .mode_strap(mode_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_active(mode_active), .ref_source(ref_source),
    .forward_rate_mult(forward_rate_mult), .csi_bw_limit_mult(csi_bw_limit_mult),
    .sensor_ref_clk(sensor_ref_clk), .sensor_ref_clk_active(sensor_ref_clk_active));

// *** verif/tb_scm_top.sv ***
// Self-checking bench for the serializer clock mode controller.
`timescale 1ns/1ps
module tb_scm_top
    import scm_pkg::*;
;
    localparam logic [63:0] RA = 64'h2011100706050403;
    localparam logic [63:0] RV = 64'h0000000108080000;
    logic clk = 1'b0;
    logic rstn, power_down_pin_n, reg_wr, reg_rd, bc_clk, ext_clk, osc_f, osc_h, s_clk, s_act;
    logic [2:0] mode_strap, mode_active;
    logic [1:0] ref_source;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fwd, bw, d;
    logic rd_seen = 1'b0, st_req = 1'b0, st_sel = 1'b0, prev = 1'b0;
    logic [31:0] cnt_obs, q_rd[$], q_st[$];
    int errors = 0, n_tests = 0, tn = 0, rises = 0;
    // Columns: clock config, mode, reference source, rate, bandwidth, sensor clock offered.
    logic [29:0] tbl [7] = '{{8'h08, 3'h0, 2'h0, 8'hA0, 8'h80, 1'b1},
        {8'h08, 3'h2, 2'h1, 8'h50, 8'h40, 1'b1},
        {8'h09, 3'h2, 2'h1, 8'h28, 8'h20, 1'b1},
        {8'h08, 3'h3, 2'h2, 8'h50, 8'h40, 1'b0},
        {8'h00, 3'h3, 2'h3, 8'h50, 8'h40, 1'b0},
        {8'h00, 3'h5, 2'h1, 8'h1C, 8'h14, 1'b1},
        {8'h08, 3'h1, 2'h0, 8'h00, 8'h00, 1'b0}};
    always #4 clk = ~clk;
    scm_far_model far_u (.backchannel_clk(bc_clk), .ref_clock_input_pin(ext_clk),
        .osc_full_rate(osc_f), .osc_half_rate(osc_h));
    scm_top dut_u (.clk(clk), .rstn(rstn), .power_down_pin_n(power_down_pin_n),
        .mode_strap(mode_strap), .backchannel_clk(bc_clk), .ref_clock_input_pin(ext_clk),
        .osc_full_rate(osc_f), .osc_half_rate(osc_h), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mode_active(mode_active), .ref_source(ref_source), .forward_rate_mult(fwd),
        .csi_bw_limit_mult(bw), .sensor_ref_clk(s_clk), .sensor_ref_clk_active(s_act));
    always @(posedge clk) begin
        rd_seen <= reg_rd;
        prev <= s_clk;
        if (s_clk && !prev) rises <= rises + 1;
    end
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    always @(negedge clk) begin
        if (rd_seen === 1'b1) cmp(q_rd.pop_front(), {24'h0, reg_rdata});
        if (st_req) cmp(q_st.pop_front(), st_sel ? cnt_obs :
            {10'h0, mode_active, ref_source, fwd, bw, s_act});
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        q_rd.push_back({24'h0, e});
        @(posedge clk);
        reg_rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic post(input logic [31:0] e, input logic sel);
        q_st.push_back(e);
        st_sel <= sel;
        st_req <= 1'b1;
        @(posedge clk);
        st_req <= 1'b0;
    endtask
    task automatic st(input logic [21:0] e);
        repeat (3) @(posedge clk);
        post({10'h0, e}, 1'b0);
    endtask
    // Window start phase is arbitrary, so one edge either way is accepted.
    task automatic ck(input int e, input int per);
        int r0;
        #(4 * per);
        r0 = rises;
        #(40 * per);
        cnt_obs = (rises - r0 + 1 >= e && rises - r0 <= e + 1) ? e : rises - r0;
        @(posedge clk);
        post(cnt_obs, 1'b1);
    endtask
    task automatic done();
        tn++;
        $display("test %0d done", tn);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        complete_run();
    end
    initial begin
        {rstn, power_down_pin_n, reg_wr, reg_rd} = 4'h0;
        mode_strap = SCM_MODE_PAR;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        void'($urandom(32'h65F4));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        st({3'h0, 2'h0, SCM_MULT_SYNC, SCM_BW_SYNC, 1'b1});
        for (int i = 0; i < 8; i++) rd(RA[8*i+:8], RV[8*i+:8]);
        done();
        wr(SCM_OFS_MODE, 8'h02);
        rd(SCM_OFS_MODE, 8'h00);
        power_down_pin_n <= 1'b1;
        repeat (12) @(posedge clk);
        rd(SCM_OFS_MODE, 8'h05);
        st({3'h5, 2'h1, SCM_MULT_PAR, SCM_BW_PAR_TEN, 1'b1});
        wr(SCM_OFS_BC_FMT, 8'h01);
        st({3'h5, 2'h1, SCM_MULT_PAR, SCM_BW_PAR_TWELVE_HF, 1'b1});
        done();
        foreach (tbl[i]) begin
            wr(SCM_OFS_CLK_CFG, tbl[i][29:22]);
            wr(SCM_OFS_BC_FMT, 8'h00);
            wr(SCM_OFS_MODE, {5'h02, tbl[i][21:19]});
            st(tbl[i][21:0]);
            rd(SCM_OFS_MODE, {5'h02, tbl[i][21:19]});
        end
        done();
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(SCM_OFS_PAR_CFG, d);
            wr(SCM_OFS_PAR_DT, ~d);
            wr(8'h20, d);
            wr(SCM_OFS_CLKOUT_M, {d[7:3], 3'b001});
            rd(SCM_OFS_PAR_CFG, d);
            rd(SCM_OFS_PAR_DT, ~d);
            rd(8'h20, 8'h00);
            wr(SCM_OFS_CLKOUT_M, {~d[7:3], 3'b011});
            rd(SCM_OFS_CLKOUT_M, {~d[7:3], 3'b001});
        end
        done();
        wr(SCM_OFS_MODE, 8'h10);
        wr(SCM_OFS_CLKOUT_N, 8'hA0);
        wr(SCM_OFS_CLKOUT_M, 8'h08);
        ck(10, 80);
        wr(SCM_OFS_CLKOUT_M, 8'h09);
        ck(5, 80);
        wr(SCM_OFS_MODE, 8'h12);
        wr(SCM_OFS_CLK_CFG, 8'h08);
        wr(SCM_OFS_CLKOUT_M, 8'h10);
        ck(10, 96);
        wr(SCM_OFS_MODE, 8'h13);
        ck(0, 80);
        done();
        complete_run();
    end
endmodule
